// ==== logic/rcms_top.sv ====
// run command gating and operation mode selection
//
// Function
// - lock 0: both start inputs honoured; negative command reverses direction
// - speed control: lock 1 forward only, lock 2 reverse only, negative no start
// - torque locked: negative command at or below starting speed gives no rotation
// - torque locked: negative, same direction, above starting speed gives reverse torque
// - position lock 0: start inputs are stroke limits, missing direction refused
// - position: lock 1 and 2 set the allowed directions, analog is torque limit, absolute value taken
// - external operation at power-on; mode selector takes 0 to 4, 6 to 8
// - mode 0: panel toggle key swaps panel and external operation
// - mode 1: speed and start from panel keys only
// - mode 6: source switching allowed while running
// - mode 7, interlock high: panel change allowed, external output stopped
// - mode 7, interlock low: change to panel refused
// - mode 8: switch input picks ext/panel, refused while running
// - mode 7: interlock low forces external operation regardless of start inputs
// - mode 7, interlock high: panel change refused while a start input is active
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "rcms_consts.svh"
module rcms_top #(
  parameter int ANA_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // terminals and panel
  input wire rcms_pkg::rcms_in_t pins_i,
  input wire logic signed [ANA_W-1:0] ana_ext_i,
  input wire logic signed [ANA_W-1:0] ana_panel_i,
  input wire logic [ANA_W-1:0] motor_speed_i,
  input wire logic motor_dir_rev_i,
  input wire logic motor_running_i,
  // to motor core
  output rcms_pkg::rcms_cmd_t cmd_o,
  output logic [ANA_W-1:0] ana_mag_o,
  output rcms_pkg::rcms_src_t src_o
);
  // ==========================================================
  // register bus
  logic [1:0] lock_r;
  rcms_pkg::rcms_ctl_t ctl_r;
  logic [3:0] mode_r;
  logic [ANA_W-1:0] start_spd_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic wr_req;
  logic [3:0] req_bits;
  logic mode_ok;

  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
  assign req_bits = (wr_req && wb_adr_i == `RCMS_OFS_REQ && wb_sel_i[0])
                    ? wb_dat_i[3:0] : 4'h0;
  // only settings 0..4 and 6..8 are legal
  assign mode_ok = (wb_dat_i[3:0] <= 4'h8) && (wb_dat_i[3:0] != 4'h5);

  // ack one cycle after request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end
  end

  // configuration writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_r <= `RCMS_LOCK_RST;
      ctl_r <= rcms_pkg::RCMS_CTL_SPEED;
      mode_r <= `RCMS_MODE_RST;
      start_spd_r <= `RCMS_START_SPD_RST;
    end else if (wr_req && wb_sel_i[0]) begin
      if (wb_adr_i == `RCMS_OFS_CTRL) begin
        if (wb_dat_i[`RCMS_CTRL_LOCK_LSB +: 2] != 2'h3) begin
          lock_r <= wb_dat_i[`RCMS_CTRL_LOCK_LSB +: 2];
        end
        if (wb_dat_i[`RCMS_CTRL_CTL_LSB +: 2] != 2'h2) begin
          ctl_r <= rcms_pkg::rcms_ctl_t'(wb_dat_i[`RCMS_CTRL_CTL_LSB +: 2]);
        end
      end else if (wb_adr_i == `RCMS_OFS_MODE) begin
        if (mode_ok) begin
          mode_r <= wb_dat_i[3:0];
        end
      end else if (wb_adr_i == `RCMS_OFS_START_SPD) begin
        start_spd_r <= wb_dat_i[ANA_W-1:0];
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_we_i) begin
      if (wb_adr_i == `RCMS_OFS_CTRL) begin
        rdat_r <= {26'h0, ctl_r, 2'h0, lock_r};
      end else if (wb_adr_i == `RCMS_OFS_MODE) begin
        rdat_r <= {28'h0, mode_r};
      end else if (wb_adr_i == `RCMS_OFS_STAT) begin
        rdat_r <= {23'h0, cmd_o, src_o};
      end else if (wb_adr_i == `RCMS_OFS_START_SPD) begin
        rdat_r <= {{(32-ANA_W){1'b0}}, start_spd_r};
      end else begin
        rdat_r <= 32'h0000_0000;
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ==========================================================
  // operation source selection
  rcms_pkg::rcms_src_t src_r;
  rcms_pkg::rcms_src_t src_nxt;
  logic start_any;
  logic panel_ok;

  assign start_any = pins_i.forward_start_input | pins_i.reverse_start_input;

  // a panel change is refused while starts are live under interlock
  always_comb begin
    panel_ok = 1'b1;
    if (mode_r == 4'h7) begin
      panel_ok = pins_i.panel_interlock_input && !start_any;
    end
  end

  always_comb begin
    src_nxt = src_r;
    case (mode_r)
      4'h0: begin
        if (pins_i.panel_source_toggle_key || req_bits[`RCMS_REQ_TOGGLE]) begin
          src_nxt = (src_r == rcms_pkg::RCMS_SRC_PANEL)
                    ? rcms_pkg::RCMS_SRC_EXT : rcms_pkg::RCMS_SRC_PANEL;
        end
      end
      4'h1: src_nxt = rcms_pkg::RCMS_SRC_PANEL;
      4'h2, 4'h3, 4'h4: src_nxt = rcms_pkg::RCMS_SRC_EXT;
      4'h6: begin
        // switching allowed while running
        if (req_bits[`RCMS_REQ_TO_PANEL]) begin
          src_nxt = rcms_pkg::RCMS_SRC_PANEL;
        end else if (req_bits[`RCMS_REQ_TO_EXT]) begin
          src_nxt = rcms_pkg::RCMS_SRC_EXT;
        end else if (req_bits[`RCMS_REQ_TO_LINK]) begin
          src_nxt = rcms_pkg::RCMS_SRC_LINK;
        end
      end
      4'h7: begin
        if (!pins_i.panel_interlock_input) begin
          src_nxt = rcms_pkg::RCMS_SRC_EXT;
        end else if ((req_bits[`RCMS_REQ_TO_PANEL]
                      || pins_i.panel_source_toggle_key) && panel_ok) begin
          src_nxt = rcms_pkg::RCMS_SRC_PANEL;
        end else if (req_bits[`RCMS_REQ_TO_EXT]) begin
          src_nxt = rcms_pkg::RCMS_SRC_EXT;
        end
      end
      4'h8: begin
        // held mode while running, change taken once stopped
        if (!motor_running_i) begin
          src_nxt = pins_i.mode_switch_input ? rcms_pkg::RCMS_SRC_EXT
                    : rcms_pkg::RCMS_SRC_PANEL;
        end
      end
      default: src_nxt = src_r;
    endcase
  end

  // external operation at power-on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_r <= rcms_pkg::RCMS_SRC_EXT;
    end else begin
      src_r <= src_nxt;
    end
  end
  assign src_o = src_r;

  // ==========================================================
  // start and speed source per mode
  logic start_from_panel;
  logic speed_from_panel;
  logic req_f;
  logic req_r;

  always_comb begin
    start_from_panel = (src_r == rcms_pkg::RCMS_SRC_PANEL);
    speed_from_panel = (src_r == rcms_pkg::RCMS_SRC_PANEL);
    if (mode_r == 4'h3) begin
      start_from_panel = 1'b0;
      speed_from_panel = 1'b1;
    end else if (mode_r == 4'h4) begin
      start_from_panel = 1'b1;
      speed_from_panel = 1'b0;
    end else if (mode_r == 4'h1) begin
      start_from_panel = 1'b1;
      speed_from_panel = 1'b1;
    end
  end
  assign req_f = start_from_panel ? pins_i.panel_forward_key
                 : pins_i.forward_start_input;
  assign req_r = start_from_panel ? pins_i.panel_reverse_key
                 : pins_i.reverse_start_input;

  // ==========================================================
  // direction gating under rotation lock
  logic signed [ANA_W-1:0] ana_sel;
  logic neg;
  logic [ANA_W-1:0] mag;
  logic ext_stop;
  rcms_pkg::rcms_cmd_t cmd_nxt;
  rcms_pkg::rcms_cmd_t cmd_r;
  logic [ANA_W-1:0] mag_r;

  assign ana_sel = speed_from_panel ? ana_panel_i : ana_ext_i;
  assign neg = ana_sel[ANA_W-1];
  assign mag = neg ? ANA_W'(-ana_sel) : ana_sel;
  // interlock mode with interlock high stops output while in external operation
  assign ext_stop = (mode_r == 4'h7) && pins_i.panel_interlock_input
                    && (src_r == rcms_pkg::RCMS_SRC_EXT);

  always_comb begin
    logic f;
    logic r;
    f = req_f && !req_r;
    r = req_r && !req_f;
    cmd_nxt = '0;
    cmd_nxt.speed_from_panel = speed_from_panel;
    cmd_nxt.output_stop = ext_stop;
    cmd_nxt.allow_fwd = 1'b1;
    cmd_nxt.allow_rev = 1'b1;
    case (ctl_r)
      rcms_pkg::RCMS_CTL_POSITION: begin
        // analog is only a torque limit, lock irrelevant to it
        if (lock_r == 2'h0) begin
          cmd_nxt.allow_fwd = req_f;
          cmd_nxt.allow_rev = req_r;
        end else begin
          cmd_nxt.allow_fwd = (lock_r != 2'h2);
          cmd_nxt.allow_rev = (lock_r != 2'h1);
        end
        cmd_nxt.run_fwd = f && cmd_nxt.allow_fwd;
        cmd_nxt.run_rev = r && cmd_nxt.allow_rev;
      end
      default: begin
        if (lock_r == 2'h1) begin
          r = 1'b0;
        end else if (lock_r == 2'h2) begin
          f = 1'b0;
        end
        if (lock_r == 2'h0) begin
          cmd_nxt.run_fwd = neg ? r : f;
          cmd_nxt.run_rev = neg ? f : r;
        end else if (!neg) begin
          cmd_nxt.run_fwd = f;
          cmd_nxt.run_rev = r;
        end else if (ctl_r == rcms_pkg::RCMS_CTL_TORQUE
                     && motor_speed_i > start_spd_r
                     && ((f && !motor_dir_rev_i)
                         || (r && motor_dir_rev_i))) begin
          // keep run, torque opposes start direction
          cmd_nxt.run_fwd = f;
          cmd_nxt.run_rev = r;
          cmd_nxt.torque_rev = 1'b1;
        end else begin
          cmd_nxt.run_fwd = 1'b0;
          cmd_nxt.run_rev = 1'b0;
        end
        cmd_nxt.allow_fwd = (lock_r != 2'h2);
        cmd_nxt.allow_rev = (lock_r != 2'h1);
      end
    endcase
    if (ext_stop) begin
      cmd_nxt.run_fwd = 1'b0;
      cmd_nxt.run_rev = 1'b0;
    end
  end

  // registered command to core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_r <= '0;
      mag_r <= '0;
    end else begin
      cmd_r <= cmd_nxt;
      mag_r <= (ctl_r == rcms_pkg::RCMS_CTL_POSITION) ? mag : ana_sel;
    end
  end
  assign cmd_o = cmd_r;
  assign ana_mag_o = mag_r;
endmodule

// ==== logic/rcms_consts.svh ====
// constants for the run command and mode select block
`ifndef RCMS_CONSTS_SVH
`define RCMS_CONSTS_SVH
// register word offsets (byte addresses)
`define RCMS_OFS_CTRL 8'h00
`define RCMS_OFS_MODE 8'h04
`define RCMS_OFS_STAT 8'h08
`define RCMS_OFS_START_SPD 8'h0C
`define RCMS_OFS_REQ 8'h10
// control register fields
`define RCMS_CTRL_LOCK_LSB 0
`define RCMS_CTRL_CTL_LSB 4
// request register bits (write one to request)
`define RCMS_REQ_TOGGLE 0
`define RCMS_REQ_TO_PANEL 1
`define RCMS_REQ_TO_EXT 2
`define RCMS_REQ_TO_LINK 3
// reset values
`define RCMS_LOCK_RST 2'h0
`define RCMS_MODE_RST 4'h0
`define RCMS_START_SPD_RST 16'h0000
`endif

// ==== logic/rcms_pkg.sv ====
// types for the run command and mode select block
package rcms_pkg;
  // control method
  typedef enum logic [1:0] {
    RCMS_CTL_SPEED = 2'h0,
    RCMS_CTL_TORQUE = 2'h1,
    RCMS_CTL_POSITION = 2'h3
  } rcms_ctl_t;
  // active operation source, gray along ext/panel/link
  typedef enum logic [1:0] {
    RCMS_SRC_EXT = 2'h0,
    RCMS_SRC_PANEL = 2'h1,
    RCMS_SRC_LINK = 2'h3
  } rcms_src_t;
  // terminal and panel inputs
  typedef struct packed {
    logic forward_start_input;
    logic reverse_start_input;
    logic panel_interlock_input;
    logic mode_switch_input;
    logic panel_forward_key;
    logic panel_reverse_key;
    logic panel_source_toggle_key;
  } rcms_in_t;
  // command to motor core
  typedef struct packed {
    logic run_fwd;
    logic run_rev;
    logic torque_rev;
    logic allow_fwd;
    logic allow_rev;
    logic speed_from_panel;
    logic output_stop;
  } rcms_cmd_t;
endpackage

// ==== test/rcms_asserts.sv ====
// port checker for the run command and mode select block
`timescale 1ns/10ps
`include "rcms_consts.svh"
module rcms_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire rcms_pkg::rcms_in_t pins_i,
  input wire logic motor_running_i,
  input wire rcms_pkg::rcms_cmd_t cmd_o,
  input wire rcms_pkg::rcms_src_t src_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // mode shadow
  logic [3:0] mode_r;
  // reserved codes never land, so the shadow stays legal
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= 4'h0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
        wb_sel_i[0] && wb_adr_i == `RCMS_OFS_MODE &&
        wb_dat_i[3:0] != 4'h5 && wb_dat_i[3:0] < 4'h9) begin
      mode_r <= wb_dat_i[3:0];
    end
  end
  // ==========================================
  // properties
  property p_ack_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack missing");
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_rst;
    disable iff (1'b0)
    rst_i |=> cmd_o == '0 && src_o == rcms_pkg::RCMS_SRC_EXT;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_one_dir;
    !(cmd_o.run_fwd && cmd_o.run_rev);
  endproperty
  a_one_dir: assert property (p_one_dir) else $error("two dirs");
  property p_ilk_ext;
    mode_r == 4'h7 && !pins_i.panel_interlock_input
      |=> src_o == rcms_pkg::RCMS_SRC_EXT;
  endproperty
  a_ilk_ext: assert property (p_ilk_ext) else $error("not ext");
  property p_m7_stop;
    mode_r == 4'h7 && pins_i.panel_interlock_input &&
      src_o == rcms_pkg::RCMS_SRC_EXT |=> cmd_o.output_stop;
  endproperty
  a_m7_stop: assert property (p_m7_stop) else $error("no stop");
  property p_m8_ext;
    mode_r == 4'h8 && !motor_running_i && pins_i.mode_switch_input
      |=> src_o == rcms_pkg::RCMS_SRC_EXT;
  endproperty
  a_m8_ext: assert property (p_m8_ext) else $error("m8 not ext");
  property p_m8_hold;
    mode_r == 4'h8 && motor_running_i |=> $stable(src_o);
  endproperty
  a_m8_hold: assert property (p_m8_hold) else $error("m8 moved");
  property p_m1;
    (mode_r == 4'h1) [*3] |->
      src_o == rcms_pkg::RCMS_SRC_PANEL && cmd_o.speed_from_panel;
  endproperty
  a_m1: assert property (p_m1) else $error("m1 not panel");
endmodule
bind rcms_top rcms_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .pins_i,
  .motor_running_i, .cmd_o, .src_o);

// ==== test/rcms_panel.sv ====
// operator panel and terminal model driving the input pins
`timescale 1ns/10ps
module rcms_panel (
  input wire logic clk_i,
  output rcms_pkg::rcms_in_t pins_o
);
  initial pins_o = '0;
  // levels move just after an edge and hold until told otherwise
  task automatic set(input logic [6:0] v);
    @(posedge clk_i);
    pins_o <= v;
  endtask
  // a keypress lasts one clock, each high cycle counts as a press
  task automatic press_toggle();
    @(posedge clk_i);
    pins_o.panel_source_toggle_key <= 1'b1;
    @(posedge clk_i);
    pins_o.panel_source_toggle_key <= 1'b0;
  endtask
endmodule

// ==== test/rcms_top_test.sv ====
// self-checking bench for the run command and mode select block
`timescale 1ns/10ps
`include "rcms_consts.svh"
module rcms_top_test;
  localparam rcms_pkg::rcms_src_t EX = rcms_pkg::RCMS_SRC_EXT;
  localparam rcms_pkg::rcms_src_t PU = rcms_pkg::RCMS_SRC_PANEL;
  localparam logic [1:0] RUN_EXP [9] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h0,
    2'h0, 2'h0, 2'h1, 2'h0};
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, dat_o;
  logic signed [15:0] ana = 16'sh0100, pana = 16'sh0100;
  logic mdir = 0;
  logic [3:0] sel = 4'hf;
  logic [15:0] spd = 16'h0000, mag;
  logic running = 0;
  logic [3:0] em = 4'h0;
  rcms_pkg::rcms_in_t pins;
  rcms_pkg::rcms_cmd_t cmd;
  rcms_pkg::rcms_src_t src;
  int mismatches = 0, n_tests = 0;
  rcms_top dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .pins_i(pins), .ana_ext_i(ana),
    .ana_panel_i(pana), .motor_speed_i(spd), .motor_dir_rev_i(mdir),
    .motor_running_i(running), .cmd_o(cmd), .ana_mag_o(mag),
    .src_o(src));
  rcms_panel pm (.clk_i, .pins_o(pins));
  // ==========================================
  // helpers
  initial forever #2 clk_i = ~clk_i;
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // classic single cycle, held until ack is seen, bounded wait
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int i;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      mismatches++;
      wrap_up();
    end else begin
      rdat = dat_o;
      {cyc, stb, we} <= 3'h0;
    end
  endtask
  // ==========================================
  // scenarios
  initial begin
    tick(3);
    rst_i <= 1'b0;
    tick(2);
    chk(src, EX);
    // every code once; reserved ones must keep the last good value
    for (int m = 0; m < 16; m++) begin
      wb(1, `RCMS_OFS_MODE, m);
      if (m != 5 && m < 9) em = m[3:0];
      wb(0, `RCMS_OFS_MODE, 0);
      chk(rdat[3:0], em);
    end
    wb(0, 8'h20, 0);
    chk(rdat, 32'h0000_0000);
    // speed control, locks 0..2 against start and sign
    wb(1, `RCMS_OFS_MODE, 2);
    for (int k = 0; k < 9; k++) begin
      wb(1, `RCMS_OFS_CTRL, k / 3);
      ana <= (k % 3 == 2) ? -16'sh0100 : 16'sh0100;
      pm.set((k % 3 == 1 || k == 8) ? 7'h20 : 7'h40);
      tick(3);
      chk({cmd.run_fwd, cmd.run_rev}, RUN_EXP[k]);
    end
    // torque, reverse lock, speed at and just over the start speed
    wb(1, `RCMS_OFS_START_SPD, 16'h0100);
    wb(1, `RCMS_OFS_CTRL, 8'h11);
    pm.set(7'h40);
    {ana, spd} <= {-16'sh0100, 16'h0100};
    tick(3);
    chk({cmd.run_fwd, cmd.run_rev, cmd.torque_rev}, 3'h0);
    spd <= 16'h0101;
    tick(3);
    chk(cmd.torque_rev, 1'b1);
    // forward lock, reverse start, motor already turning reverse
    wb(1, `RCMS_OFS_CTRL, 8'h12);
    pm.set(7'h20);
    mdir <= 1'b1;
    tick(3);
    chk({cmd.run_rev, cmd.torque_rev}, 2'h3);
    // position: stroke limits and magnitude of a negative command
    wb(1, `RCMS_OFS_CTRL, 8'h30);
    ana <= -16'sh012C;
    tick(3);
    chk({cmd.allow_fwd, cmd.allow_rev}, 2'h1);
    chk(mag, 16'h012C);
    wb(1, `RCMS_OFS_CTRL, 0);
    // mode 0 toggles by key and by request
    wb(1, `RCMS_OFS_MODE, 0);
    pm.set(7'h00);
    pm.press_toggle();
    tick(3);
    chk(src, PU);
    wb(1, `RCMS_OFS_REQ, 1);
    tick(3);
    chk(src, EX);
    // mode 1 runs from panel keys only
    wb(1, `RCMS_OFS_MODE, 1);
    pm.set(7'h04);
    tick(3);
    chk({src, cmd.speed_from_panel, cmd.run_fwd}, {PU, 2'h3});
    pm.set(7'h40);
    tick(3);
    chk(cmd.run_fwd, 1'b0);
    // mode 7 interlock cases
    wb(1, `RCMS_OFS_MODE, 7);
    pm.set(7'h50);
    wb(1, `RCMS_OFS_REQ, 2);
    tick(3);
    chk({src, cmd.output_stop}, {EX, 1'b1});
    pm.set(7'h00);
    wb(1, `RCMS_OFS_REQ, 2);
    tick(3);
    chk(src, EX);
    pm.set(7'h10);
    wb(1, `RCMS_OFS_REQ, 2);
    tick(3);
    chk(src, PU);
    pm.set(7'h00);
    tick(3);
    chk(src, EX);
    // mode 8 follows the switch only while stopped
    pm.set(7'h08);
    wb(1, `RCMS_OFS_MODE, 8);
    tick(3);
    chk(src, EX);
    running <= 1'b1;
    pm.set(7'h00);
    tick(3);
    chk(src, EX);
    running <= 1'b0;
    tick(3);
    chk(src, PU);
    // mode 6 switches to the link while running
    running <= 1'b1;
    wb(1, `RCMS_OFS_MODE, 6);
    wb(1, `RCMS_OFS_REQ, 8);
    tick(3);
    chk(src, rcms_pkg::RCMS_SRC_LINK);
    // reset again mid-run: the link source falls back to external
    rst_i <= 1'b1;
    tick(3);
    rst_i <= 1'b0;
    tick(2);
    chk(src, EX);
    // combined modes: terminal analog negative, panel analog positive
    wb(1, `RCMS_OFS_MODE, 3);
    pm.set(7'h40);
    tick(3);
    chk({cmd.speed_from_panel, cmd.run_fwd}, 2'h3);
    wb(1, `RCMS_OFS_MODE, 4);
    pm.set(7'h02);
    tick(3);
    chk({cmd.speed_from_panel, cmd.run_fwd}, 2'h1);
    // a write without byte lane 0 must leave the mode alone
    sel <= 4'he;
    wb(1, `RCMS_OFS_MODE, 2);
    sel <= 4'hf;
    wb(0, `RCMS_OFS_MODE, 0);
    chk(rdat[3:0], 4'h4);
    wrap_up();
  end
endmodule
